// ===== src/counter_map.svh
/*
  offsets, field positions, reset values and timing counts of the event counter.
  assumes a 50 MHz module clock and one aligned 32-bit word per register.
*/
`ifndef COUNTER_MAP_SVH
`define COUNTER_MAP_SVH

`define OFF_CTRL 32'h0000_0000
`define OFF_LOAD 32'h0000_0004
`define OFF_VALUE 32'h0000_0008
`define OFF_STATUS 32'h0000_000c
`define OFF_CLEAR 32'h0000_0010
`define OFF_IRQEN 32'h0000_0014
`define OFF_LATCH 32'h0000_0018

`define CTRL_MODE 0
`define CTRL_GFN 1
`define CTRL_SWG 2
`define CTRL_CFRQ 4
`define CTRL_LFRQ 8
`define FRQ_W 3
`define CTRL_RST 32'h0000_0350

`define STS_OVF 0
`define STS_UNF 1
`define STS_OPEN 2

`define CNT_MAX 32'sh7fff_ffff
`define CNT_MIN 32'sh8000_0000

`define CLK_MHZ 50
`define T1K_NS 400000
`define T2K_NS 200000
`define T5K_NS 80000
`define T10K_NS 40000
`define T30K_NS 13000
`define T60K_NS 6700
`define NS2CYC(t) ((((t) * `CLK_MHZ) + 999) / 1000)

`endif

// ===== src/counter_pkg.sv
/*
  types shared by the event counter and its input filter.
  assumes an AHB-Lite master with single word transfers.
*/
package counter_pkg;

  typedef enum logic {MODE_CONT, MODE_ONCE} mode_t;
  typedef enum logic {GATE_CANCEL, GATE_INTERRUPT} gatefn_t;
  typedef enum logic {GATE_CLOSED, GATE_OPEN} gate_state_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef struct packed {
    logic latchIn;
    logic hwGate;
    logic countDir;
    logic countPulse;
  } field_pins_t;

endpackage : counter_pkg

// ===== src/pulse_filter.sv
/*
  two-stage synchroniser and minimum pulse width filter for one field pin.
  assumes minCyc is at least 1 and changes only between pulses.
*/
module pulse_filter
  import counter_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic [15:0] minCyc,
  output logic filt
);

  logic sync1_reg;
  logic sync2_reg;
  logic [15:0] run_reg;
  wire differs = sync2_reg != filt;
  wire longEnough = run_reg >= (minCyc - 16'h0001);

  // a level is passed on only after it held for minCyc cycles; shorter glitches vanish
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      run_reg <= 16'h0000;
      filt <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      run_reg <= (differs && !longEnough) ? run_reg + 16'h0001 : 16'h0000;
      if (differs && longEnough)
        filt <= sync2_reg;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_filter_min;
    differs && !longEnough |=> $stable(filt);
  endproperty
  a_filter_min: assert property (p_filter_min) else $error("filter passed a short pulse");

endmodule : pulse_filter

// ===== src/wraparound_counter.sv
/*
  32-bit signed up/down event counter with continuous and count-once modes,
  sticky wrap flags, interrupt, latch and AHB-Lite register slave.
  assumes field pins are asynchronous and the bus master issues single word transfers.
*/
// Summary of operation
// - count and gate pulses shorter than the selected minimum width are rejected
// - latch input has its own frequency filter, default 10kHz
// - continuous mode starts counting from the load value
// - continuous: up pulse at upper limit gives the lower limit
// - continuous: down pulse at lower limit gives the upper limit
// - limits are the full signed 32-bit range
// - overflow and underflow set sticky flags until a clear request
// - overflow or underflow raise the interrupt only when enabled
// - count-once mode starts from load value, counts up and down
// - count-once: wrap loads opposite limit and closes the gate
// - restart with interrupt gate function resumes current value
// - restart with cancel gate function reloads the load value
// - count and gate frequency setting defaults to 60kHz
// - each interrupt has its own enable, off after reset
`include "counter_map.svh"

module wraparound_counter
#(
  parameter logic [15:0] FILT_1K_CYC = 16'(`NS2CYC(`T1K_NS)),
  parameter logic [15:0] FILT_2K_CYC = 16'(`NS2CYC(`T2K_NS))
)
(
  input wire logic clk,
  input wire logic rst_n,
  input counter_pkg::ahb_req_t bus,
  output counter_pkg::ahb_rsp_t rsp,
  input counter_pkg::field_pins_t pins,
  output logic irq
);
  import counter_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [31:0] ctrl_reg;
  logic signed [31:0] load_reg;
  logic signed [31:0] value_reg;
  logic signed [31:0] value_next;
  logic signed [31:0] latch_reg;
  logic [1:0] sts_reg;
  logic [1:0] sts_next;
  logic [1:0] irqEn_reg;
  logic started_reg;
  logic gateInD_reg;
  logic pulseD_reg;
  logic latchD_reg;
  logic wrPend_reg;
  logic [31:0] wrAddr_reg;
  gate_state_t gate_reg;
  gate_state_t gate_next;

  //////////////////////////////////////////////////////////////////////////////
  // input filters

  wire [15:0] cycTab [8];
  assign cycTab[0] = FILT_1K_CYC;
  assign cycTab[1] = FILT_2K_CYC;
  assign cycTab[2] = 16'(`NS2CYC(`T5K_NS));
  assign cycTab[3] = 16'(`NS2CYC(`T10K_NS));
  assign cycTab[4] = 16'(`NS2CYC(`T30K_NS));
  assign cycTab[5] = 16'(`NS2CYC(`T60K_NS));
  assign cycTab[6] = 16'(`NS2CYC(`T60K_NS));
  assign cycTab[7] = 16'(`NS2CYC(`T60K_NS));

  wire [`FRQ_W-1:0] cntFrq = ctrl_reg[`CTRL_CFRQ +: `FRQ_W];
  wire [`FRQ_W-1:0] latFrq = ctrl_reg[`CTRL_LFRQ +: `FRQ_W];
  wire [3:0] pinVec = pins;
  logic [3:0] filtVec;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_filt
      // latch channel uses its own setting
      pulse_filter u_filt (
        .clk(clk),
        .rst_n(rst_n),
        .pin(pinVec[g]),
        .minCyc((g == 3) ? cycTab[latFrq] : cycTab[cntFrq]),
        .filt(filtVec[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // gate and counting decisions

  wire onceMode = ctrl_reg[`CTRL_MODE] == MODE_ONCE;
  wire cancelFn = ctrl_reg[`CTRL_GFN] == GATE_CANCEL;
  wire gateIn = ctrl_reg[`CTRL_SWG] & filtVec[2];
  wire gateRise = gateIn & ~gateInD_reg;
  wire gateFall = ~gateIn & gateInD_reg;
  wire isOpen = gate_reg == GATE_OPEN;
  wire opening = !isOpen && gateRise;
  wire reload = opening && (cancelFn || !started_reg);
  wire countEv = isOpen && filtVec[0] && !pulseD_reg;
  wire up = filtVec[1];
  wire atMax = value_reg == `CNT_MAX;
  wire atMin = value_reg == `CNT_MIN;
  wire ovfEv = countEv && up && atMax;
  wire unfEv = countEv && !up && atMin;
  wire latchEv = isOpen && filtVec[3] && !latchD_reg;

  // a restart edge in the same cycle as a wrap is impossible: the gate is still open
  always_comb
  begin
    gate_next = gate_reg;
    case (gate_reg)
      GATE_CLOSED:
        if (gateRise)
          gate_next = GATE_OPEN;
      GATE_OPEN:
        if (gateFall || (onceMode && (ovfEv || unfEv)))
          gate_next = GATE_CLOSED;
      default:
        gate_next = GATE_CLOSED;
    endcase
  end

  always_comb
  begin
    if (reload)
      value_next = load_reg;
    else if (ovfEv)
      value_next = `CNT_MIN;
    else if (unfEv)
      value_next = `CNT_MAX;
    else if (countEv)
      value_next = up ? value_reg + 32'sh0000_0001 : value_reg - 32'sh0000_0001;
    else
      value_next = value_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, read data prepared in the address phase

  wire addrPhase = bus.hsel && bus.htrans[1] && bus.hready;
  wire wrNow = wrPend_reg;
  wire clrHit = wrNow && (wrAddr_reg == `OFF_CLEAR);
  wire [1:0] clrBits = clrHit ? bus.hwdata[1:0] : 2'h0;
  wire irqEnWr = wrNow && (wrAddr_reg == `OFF_IRQEN);
  // irq must see an enable written this cycle, or it lags the register by one edge
  wire [1:0] irqEn_next = irqEnWr ? bus.hwdata[1:0] : irqEn_reg;
  wire [31:0] stsWord = {29'h0, isOpen, sts_reg};
  wire [31:0] rdSel =
    (bus.haddr == `OFF_CTRL) ? ctrl_reg :
    (bus.haddr == `OFF_LOAD) ? load_reg :
    (bus.haddr == `OFF_VALUE) ? value_reg :
    (bus.haddr == `OFF_STATUS) ? stsWord :
    (bus.haddr == `OFF_IRQEN) ? {30'h0, irqEn_reg} :
    (bus.haddr == `OFF_LATCH) ? latch_reg : 32'h0000_0000;

  // a new event beats a clear of the same flag
  assign sts_next = (sts_reg & ~clrBits) | {unfEv, ovfEv};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 32'h0000_0000;
      rsp <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
    end
    else
    begin
      wrPend_reg <= addrPhase && bus.hwrite;
      wrAddr_reg <= bus.haddr;
      rsp.hrdata <= (addrPhase && !bus.hwrite) ? rdSel : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `CTRL_RST;
      load_reg <= 32'sh0000_0000;
      irqEn_reg <= 2'h0;
    end
    else if (wrNow)
    begin
      if (wrAddr_reg == `OFF_CTRL)
        ctrl_reg <= bus.hwdata & 32'h0000_0777;
      if (wrAddr_reg == `OFF_LOAD)
        load_reg <= bus.hwdata;
      if (wrAddr_reg == `OFF_IRQEN)
        irqEn_reg <= bus.hwdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter state

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_reg <= 32'sh0000_0000;
      latch_reg <= 32'sh0000_0000;
      sts_reg <= 2'h0;
      gate_reg <= GATE_CLOSED;
      started_reg <= 1'b0;
      gateInD_reg <= 1'b0;
      pulseD_reg <= 1'b0;
      latchD_reg <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      value_reg <= value_next;
      sts_reg <= sts_next;
      gate_reg <= gate_next;
      started_reg <= started_reg | opening;
      gateInD_reg <= gateIn;
      pulseD_reg <= filtVec[0];
      latchD_reg <= filtVec[3];
      if (latchEv)
        latch_reg <= value_reg;
      irq <= |(sts_next & irqEn_next);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_upAtMax;
    countEv && up && atMax;
  endsequence

  sequence s_dnAtMin;
    countEv && !up && atMin;
  endsequence

  property p_wrap_up;
    s_upAtMax |=> value_reg == `CNT_MIN;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("no wrap to lower limit");

  property p_wrap_dn;
    s_dnAtMin |=> value_reg == `CNT_MAX;
  endproperty
  a_wrap_dn: assert property (p_wrap_dn) else $error("no wrap to upper limit");

  property p_ovf_flag;
    s_upAtMax |=> sts_reg[`STS_OVF] ##1 (sts_reg[`STS_OVF] || $past(clrHit));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag lost");

  property p_unf_hold;
    sts_reg[`STS_UNF] && !clrBits[`STS_UNF] |=> sts_reg[`STS_UNF];
  endproperty
  a_unf_hold: assert property (p_unf_hold) else $error("underflow flag dropped");

  property p_irq;
    ##1 irq == |(sts_reg & irqEn_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow flags");

  property p_once_close;
    onceMode ##0 (s_upAtMax or s_dnAtMin) |=> !isOpen ##1 (isOpen == $past(gateRise));
  endproperty
  a_once_close: assert property (p_once_close) else $error("gate not closed after wrap");

  property p_hold;
    !isOpen && !reload |=> $stable(value_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("value moved with closed gate");

  property p_cancel;
    opening && (cancelFn || !started_reg) |=> value_reg == $past(load_reg) && isOpen;
  endproperty
  a_cancel: assert property (p_cancel) else $error("no reload on start");

  property p_resume;
    opening && !cancelFn && started_reg |=> $stable(value_reg) && isOpen;
  endproperty
  a_resume: assert property (p_resume) else $error("value changed on resume");

  property p_unf_flag;
    s_dnAtMin |=> sts_reg[`STS_UNF];
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("underflow flag not set");

  property p_ovf_clear;
    clrBits[`STS_OVF] && !ovfEv |=> !sts_reg[`STS_OVF];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_cont_wrap;
    !onceMode ##0 (s_upAtMax or s_dnAtMin) ##0 !gateFall |=> isOpen;
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) else $error("continuous wrap stopped counting");

  property p_step_up;
    countEv && up && !atMax |=> value_reg == $past(value_reg) + 32'sh0000_0001;
  endproperty
  a_step_up: assert property (p_step_up) else $error("up count step wrong");

  property p_step_dn;
    countEv && !up && !atMin |=> value_reg == $past(value_reg) - 32'sh0000_0001;
  endproperty
  a_step_dn: assert property (p_step_dn) else $error("down count step wrong");

endmodule : wraparound_counter

// ===== testbench/pulse_source.sv
/*
  behavioural field encoder: drives count, direction, hardware gate and latch pins.
  assumes the bench calls its tasks from one process, right after a rising clock edge.
*/
module pulse_source
(
  input wire logic clk,
  output counter_pkg::field_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import counter_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // hardware gate rests high so the soft gate alone makes the gate edges
  initial pins = '{latchIn: 1'b0, hwGate: 1'b1, countDir: 1'b0, countPulse: 1'b0};

  // direction settles before the rise; low gap kept above the filter width
  task automatic count(input logic up, input int hi);
    @(posedge clk);
    pins.countDir <= up;
    repeat (4) @(posedge clk);
    pins.countPulse <= 1'b1;
    repeat (hi) @(posedge clk);
    pins.countPulse <= 1'b0;
    repeat (400) @(posedge clk);
  endtask : count

  // long tail so a filtered latch edge has landed before the bench reads
  task automatic latch(input int hi);
    @(posedge clk);
    pins.latchIn <= 1'b1;
    repeat (hi) @(posedge clk);
    pins.latchIn <= 1'b0;
    repeat (2200) @(posedge clk);
  endtask : latch
endmodule : pulse_source

// ===== testbench/tb_wraparound_and_single_shot_counter.sv
/*
  self-checking bench: register reads, wraps, sticky flags, interrupt, count-once gate, latch.
  assumes the counter package, map header, design and pulse source are compiled first.
*/
`include "counter_map.svh"
module tb_wraparound_and_single_shot_counter;
  timeunit 1ns;
  timeprecision 1ps;
  import counter_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ahb_req_t busQ = '0;
  ahb_req_t busIn;
  ahb_rsp_t rsp;
  field_pins_t pins;
  logic irq;
  logic [31:0] expQ[$];
  logic pendRd = 1'b0;
  logic [31:0] cnt;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  always_comb
  begin
    busIn = busQ;
    busIn.hready = rsp.hreadyout;
  end

  // short 1k/2k filters keep the run brief
  wraparound_counter #(.FILT_1K_CYC(16'h0028), .FILT_2K_CYC(16'h0014)) DUT (.clk(clk), .rst_n(rst_n),
    .bus(busIn), .rsp(rsp), .pins(pins), .irq(irq));
  pulse_source src (.clk(clk), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task test_done;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // read data sits in the data phase, so compare at the edge that ends it
  always @(posedge clk)
  begin
    cycles++;
    if (pendRd)
    begin
      chk(rsp.hrdata, expQ.pop_front());
      chk({30'h0, rsp.hreadyout, rsp.hresp}, 32'h0000_0002);
    end
    pendRd <= busIn.hsel & busIn.htrans[1] & ~busIn.hwrite & rsp.hreadyout;
    if (cycles == 40000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    busQ <= '{hsel: 1'b1, haddr: a, htrans: 2'b10, hwrite: wr, hsize: 3'b010, hready: 1'b1, hwdata: busQ.hwdata};
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    busQ.htrans <= 2'b00;
    busQ.hsel <= 1'b0;
    busQ.hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
  endtask : xfer

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  function automatic int hi();
    return 345 + ($urandom % 16);
  endfunction : hi

  task automatic irqIs(input logic e);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqIs

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(42));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFF_CTRL, `CTRL_RST);
    rd(`OFF_IRQEN, 32'h0000_0000);
    rd(32'h0000_0040, 32'h0000_0000);
    // hardware gate filter must pass its high level before the soft gate opens
    repeat (400) @(posedge clk);
    xfer(1'b1, `OFF_LOAD, `CNT_MAX - 1);
    xfer(1'b1, `OFF_IRQEN, 32'h0000_0001);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0354);
    rd(`OFF_VALUE, `CNT_MAX - 1);
    src.count(1'b1, hi());
    src.count(1'b1, hi());
    rd(`OFF_VALUE, `CNT_MIN);
    rd(`OFF_STATUS, 32'h0000_0005);
    irqIs(1'b1);
    xfer(1'b1, `OFF_CLEAR, 32'h0000_0001);
    rd(`OFF_STATUS, 32'h0000_0004);
    irqIs(1'b0);
    src.count(1'b0, hi());
    rd(`OFF_VALUE, `CNT_MAX);
    rd(`OFF_STATUS, 32'h0000_0006);
    irqIs(1'b0);
    xfer(1'b1, `OFF_IRQEN, 32'h0000_0003);
    irqIs(1'b1);
    // too short for the 60kHz count filter
    src.count(1'b1, 100);
    rd(`OFF_VALUE, `CNT_MAX);
    // wider than the count filter but below the 10kHz latch filter
    src.latch(1000);
    rd(`OFF_LATCH, 32'h0000_0000);
    src.latch(2100);
    rd(`OFF_LATCH, `CNT_MAX);
    // codes 0 and 1 select the shortened filters
    xfer(1'b1, `OFF_CTRL, 32'h0000_0304);
    src.count(1'b0, 50);
    rd(`OFF_VALUE, `CNT_MAX - 1);
    src.count(1'b1, 30);
    rd(`OFF_VALUE, `CNT_MAX - 1);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0314);
    src.count(1'b1, 30);
    rd(`OFF_VALUE, `CNT_MAX);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0354);
    cnt = `CNT_MAX;
    for (int i = 0; i < 4; i++)
    begin
      logic up;
      up = 1'($urandom);
      src.count(up, hi());
      cnt = up ? cnt + 32'h1 : cnt - 32'h1;
      rd(`OFF_VALUE, cnt);
    end
    xfer(1'b1, `OFF_CLEAR, 32'h0000_0003);
    irqIs(1'b0);
    // count once, cancel gate function
    xfer(1'b1, `OFF_CTRL, 32'h0000_0351);
    xfer(1'b1, `OFF_LOAD, `CNT_MAX);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0355);
    rd(`OFF_VALUE, `CNT_MAX);
    src.count(1'b1, hi());
    rd(`OFF_VALUE, `CNT_MIN);
    rd(`OFF_STATUS, 32'h0000_0001);
    src.count(1'b1, hi());
    rd(`OFF_VALUE, `CNT_MIN);
    xfer(1'b1, `OFF_CLEAR, 32'h0000_0003);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0351);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0355);
    rd(`OFF_VALUE, `CNT_MAX);
    // count once, interrupt gate function
    xfer(1'b1, `OFF_CTRL, 32'h0000_0357);
    src.count(1'b1, hi());
    xfer(1'b1, `OFF_CLEAR, 32'h0000_0003);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0353);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0357);
    rd(`OFF_VALUE, `CNT_MIN);
    src.count(1'b0, hi());
    rd(`OFF_VALUE, `CNT_MAX);
    rd(`OFF_STATUS, 32'h0000_0002);
    irqIs(1'b1);
    test_done();
  end
endmodule : tb_wraparound_and_single_shot_counter
